// ===== uma_aux_modes.sv
`timescale 1ns/10ps
`default_nettype none
`include "uma_regs.svh"

module uma_aux_modes
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_efr_enh,
  input wire logic i_efr_spec,
  input wire logic i_msr_multidrop,
  input wire logic i_msr_ir11,
  input wire logic i_mcr_ir,
  input wire logic i_mcr_loop,
  input wire logic i_mcr_rts,
  input wire logic i_mcr_dtr,
  input wire logic i_ier_sleep,
  input wire logic i_fcr_wake_ie,
  input wire logic [2:0] i_lcr_parity,
  input wire logic [1:0] i_lcr_wlen,
  input wire logic [7:0] i_second_stop_char,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_char,
  input wire logic i_rx_parity,
  input wire logic i_rx_perr,
  input wire logic i_rx_en_set,
  input wire logic i_rx_en_clr,
  input wire logic i_int_pending,
  input wire logic [3:0] i_msr_delta,
  input wire logic i_divisor_nz,
  input wire logic i_txf_empty,
  input wire logic i_rxf_empty,
  input wire logic i_thr_write,
  input wire logic i_msr_read,
  input wire logic i_isr_read,
  input wire logic i_tick16,
  input wire logic i_bit_start,
  input wire logic i_tx_shift,
  input wire logic i_rx_pin,
  input wire logic i_power_save_pin,
  input wire logic i_cts_n,
  input wire logic i_dsr_n,
  input wire logic i_cd_n,
  input wire logic i_ri_n,
  input wire uma_pkg::uma_bus_t i_bus,
  output logic o_push,
  output logic [7:0] o_push_data,
  output logic o_push_perr,
  output logic o_lsr_int,
  output logic o_rx_enabled,
  output logic o_wake_int,
  output logic o_tx_pin,
  output logic o_rts_n,
  output logic o_dtr_n,
  output logic o_rx_serial,
  output logic [3:0] o_modem_n,
  output logic o_osc_en,
  output logic o_sleep,
  output logic o_power_save,
  output uma_pkg::uma_bus_t o_bus
);
  import uma_pkg::*;

  uma_core_t r;
  uma_core_t next_r;
  logic [5:0] pins;
  logic md_on;
  logic auto_on;
  logic ir_on;
  logic is_addr;
  logic addr_match;
  logic [7:0] wl_mask;
  logic rx_level;
  logic rx_fall;
  logic modem_chg;
  logic wake;
  logic sleep_ok;

  uma_ir_if ir ();

  uma_sync3 u_sync
  (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d({i_ri_n, i_cd_n, i_dsr_n, i_cts_n, i_power_save_pin, i_rx_pin}),
    .o_q(pins)
  );

  uma_irda u_irda
  (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .ir(ir)
  );

  assign ir_on = i_mcr_ir;
  assign ir.ir_en = ir_on;
  assign ir.ir11 = i_msr_ir11 && i_efr_enh;
  assign ir.tick = i_tick16;
  assign ir.bit_start = i_bit_start;
  assign ir.tx_bit = i_tx_shift;
  assign ir.rx_pin = pins[`UMA_SYNC_RX];

  // Multidrop relies on the host framing with forced parity zero.
  assign md_on = i_msr_multidrop && i_efr_enh && (i_lcr_parity == `UMA_LCR_FORCE0);
  assign auto_on = md_on && i_efr_spec;
  assign is_addr = i_rx_parity;

  always_comb
  begin
    case (i_lcr_wlen)
      2'h0: wl_mask = 8'h1f;
      2'h1: wl_mask = 8'h3f;
      2'h2: wl_mask = 8'h7f;
      default: wl_mask = 8'hff;
    endcase
  end

  assign addr_match = ((i_rx_char ^ i_second_stop_char) & wl_mask) == 8'h00;

  // Receive level as seen by the receiver: one is idle in both modes.
  assign rx_level = ir_on ? ir.rx_bit : pins[`UMA_SYNC_RX];
  assign rx_fall = r.rx_prev && !rx_level;
  assign modem_chg = !i_mcr_loop && (pins[5:2] != r.modem_prev);

  // Host writes cannot reach the block while the bus is isolated.
  assign wake = rx_fall || modem_chg || (i_thr_write && !r.power_save);

  assign sleep_ok = i_ier_sleep && !i_int_pending && !r.wake_int
    && (i_msr_delta == 4'h0) && rx_level && i_divisor_nz
    && i_txf_empty && i_rxf_empty && !r.modem_woke;

  always_comb
  begin
    next_r = r;
    next_r.push = 1'b0;
    next_r.lsr_int = 1'b0;
    next_r.rx_prev = rx_level;
    next_r.modem_prev = pins[5:2];

    // Software steering of the receiver in both multidrop modes.
    if (i_rx_en_set)
    begin
      next_r.rx_en = 1'b1;
    end
    else if (i_rx_en_clr)
    begin
      next_r.rx_en = 1'b0;
    end

    if (i_rx_valid)
    begin
      next_r.push_data = i_rx_char;
      if (!md_on)
      begin
        next_r.push = 1'b1;
        next_r.push_perr = i_rx_perr;
      end
      else if (auto_on)
      begin
        if (is_addr)
        begin
          if (addr_match)
          begin
            next_r.rx_en = 1'b1;
            next_r.push = 1'b1;
            next_r.push_perr = i_rx_parity;
            next_r.lsr_int = 1'b1;
          end
          else
          begin
            next_r.rx_en = 1'b0;
          end
        end
        else if (r.rx_en)
        begin
          next_r.push = 1'b1;
          next_r.push_perr = 1'b0;
        end
      end
      else
      begin
        if (is_addr)
        begin
          next_r.push = 1'b1;
          next_r.push_perr = 1'b1;
          next_r.lsr_int = 1'b1;
        end
        else if (r.rx_en)
        begin
          next_r.push = 1'b1;
          next_r.push_perr = 1'b0;
        end
      end
    end

    // Modem-caused wake stays on record until the host reads modem status.
    if (r.sleep_state == UMA_ASLEEP && modem_chg)
    begin
      next_r.modem_woke = 1'b1;
    end
    else if (i_msr_read)
    begin
      next_r.modem_woke = 1'b0;
    end

    case (r.sleep_state)
      UMA_AWAKE:
      begin
        if (sleep_ok && !wake)
        begin
          next_r.sleep_state = UMA_ASLEEP;
        end
      end
      UMA_ASLEEP:
      begin
        if (!i_ier_sleep)
        begin
          next_r.sleep_state = UMA_AWAKE;
        end
        else if (wake)
        begin
          next_r.sleep_state = UMA_GUARD;
          next_r.guard = `UMA_WAKE_GUARD;
        end
      end
      UMA_GUARD:
      begin
        // Gives the wake cause time to show as an interrupt before re-sleep.
        if (r.guard == 3'h1)
        begin
          next_r.sleep_state = UMA_AWAKE;
        end
        next_r.guard = r.guard - 3'h1;
      end
      default:
      begin
        next_r.sleep_state = UMA_AWAKE;
      end
    endcase

    // Setting on the wake edge wins over a clearing status read.
    if (!i_fcr_wake_ie)
    begin
      next_r.wake_int = 1'b0;
    end
    else if (r.sleep_state == UMA_ASLEEP && next_r.sleep_state == UMA_GUARD)
    begin
      next_r.wake_int = 1'b1;
    end
    else if (i_isr_read)
    begin
      next_r.wake_int = 1'b0;
    end

    next_r.osc_en = next_r.sleep_state != UMA_ASLEEP;
    next_r.power_save = (next_r.sleep_state == UMA_ASLEEP)
      && pins[`UMA_SYNC_PS];
    if (!next_r.power_save)
    begin
      next_r.bus = i_bus;
    end

    if (i_mcr_loop)
    begin
      next_r.tx_pin = 1'b1;
      next_r.rts_n = 1'b1;
      next_r.dtr_n = 1'b1;
      next_r.rx_serial = i_tx_shift;
      next_r.modem_n = `UMA_RST_MODEM;
    end
    else
    begin
      next_r.tx_pin = ir_on ? ir.tx_pulse : i_tx_shift;
      next_r.rts_n = !i_mcr_rts;
      next_r.dtr_n = !i_mcr_dtr;
      next_r.rx_serial = rx_level;
      next_r.modem_n = pins[5:2];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      r <= '{
        sleep_state: UMA_AWAKE,
        guard: 3'h0,
        rx_en: 1'b0,
        push: 1'b0,
        push_data: `UMA_RST_DATA,
        push_perr: 1'b0,
        lsr_int: 1'b0,
        wake_int: 1'b0,
        modem_woke: 1'b0,
        modem_prev: `UMA_RST_MODEM,
        rx_prev: 1'b1,
        tx_pin: 1'b1,
        rts_n: 1'b1,
        dtr_n: 1'b1,
        rx_serial: 1'b1,
        modem_n: `UMA_RST_MODEM,
        osc_en: 1'b1,
        power_save: 1'b0,
        bus: `UMA_RST_BUS
      };
    end
    else
    begin
      r <= next_r;
    end
  end

  assign o_push = r.push;
  assign o_push_data = r.push_data;
  assign o_push_perr = r.push_perr;
  assign o_lsr_int = r.lsr_int;
  assign o_rx_enabled = r.rx_en;
  assign o_wake_int = r.wake_int;
  assign o_tx_pin = r.tx_pin;
  assign o_rts_n = r.rts_n;
  assign o_dtr_n = r.dtr_n;
  assign o_rx_serial = r.rx_serial;
  assign o_modem_n = r.modem_n;
  assign o_osc_en = r.osc_en;
  assign o_sleep = r.sleep_state == UMA_ASLEEP ? 1'b1 : 1'b0;
  assign o_power_save = r.power_save;
  assign o_bus = r.bus;
endmodule // uma_aux_modes

`default_nettype wire

// ===== uma_regs.svh
`ifndef UMA_REGS_SVH
`define UMA_REGS_SVH

// Infrared pulse widths and bit period, counted in ticks of the 16x baud clock.
`define UMA_IR10_TICKS 5'h03
`define UMA_IR11_TICKS 5'h04
`define UMA_BIT_TICKS 5'h10

// Line control parity field value that forces parity to zero.
`define UMA_LCR_FORCE0 3'h7

// Clock cycles the block stays awake after a wake-up before it may sleep again.
`define UMA_WAKE_GUARD 3'h4

// Synchroniser reset value, bit order {ri_n, cd_n, dsr_n, cts_n, power_save_pin, rx}.
`define UMA_SYNC_RST 6'h3d
`define UMA_SYNC_RX 0
`define UMA_SYNC_PS 1
`define UMA_SYNC_MODEM_LO 2

// Reset values of the control outputs.
`define UMA_RST_BUS 12'h000
`define UMA_RST_DATA 8'h00
`define UMA_RST_MODEM 4'hf

`endif

// ===== uma_pkg.sv
package uma_pkg;

  typedef logic [11:0] uma_bus_t;

  typedef enum logic [1:0]
  {
    UMA_AWAKE = 2'b00,
    UMA_ASLEEP = 2'b01,
    UMA_GUARD = 2'b10
  } uma_sleep_t;

  typedef struct packed
  {
    logic [5:0] ff1;
    logic [5:0] ff2;
    logic [5:0] ff3;
    logic [5:0] q;
  } uma_sync_t;

  typedef struct packed
  {
    logic [4:0] tx_cnt;
    logic tx_pulse;
    logic [4:0] rx_cnt;
    logic rx_prev;
    logic rx_bit;
  } uma_ir_t;

  typedef struct packed
  {
    uma_sleep_t sleep_state;
    logic [2:0] guard;
    logic rx_en;
    logic push;
    logic [7:0] push_data;
    logic push_perr;
    logic lsr_int;
    logic wake_int;
    logic modem_woke;
    logic [3:0] modem_prev;
    logic rx_prev;
    logic tx_pin;
    logic rts_n;
    logic dtr_n;
    logic rx_serial;
    logic [3:0] modem_n;
    logic osc_en;
    logic power_save;
    uma_bus_t bus;
  } uma_core_t;

endpackage

// ===== uma_ir_if.sv
`timescale 1ns/10ps
`default_nettype none

interface uma_ir_if;
  logic ir_en;
  logic ir11;
  logic tick;
  logic bit_start;
  logic tx_bit;
  logic rx_pin;
  logic tx_pulse;
  logic rx_bit;

  modport core (output ir_en, ir11, tick, bit_start, tx_bit, rx_pin, input tx_pulse, rx_bit);
  modport codec (input ir_en, ir11, tick, bit_start, tx_bit, rx_pin, output tx_pulse, rx_bit);
endinterface // uma_ir_if

`default_nettype wire

// ===== uma_sync3.sv
`timescale 1ns/10ps
`default_nettype none
`include "uma_regs.svh"

module uma_sync3
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [5:0] i_d,
  output logic [5:0] o_q
);
  import uma_pkg::*;

  uma_sync_t r;
  uma_sync_t next_r;

  // A bit is accepted only once the second and third stages agree.
  always_comb
  begin
    next_r = r;
    next_r.ff1 = i_d;
    next_r.ff2 = r.ff1;
    next_r.ff3 = r.ff2;
    for (int i = 0; i < 6; i++)
    begin
      if (r.ff2[i] == r.ff3[i])
      begin
        next_r.q[i] = r.ff3[i];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      r <= {`UMA_SYNC_RST, `UMA_SYNC_RST, `UMA_SYNC_RST, `UMA_SYNC_RST};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign o_q = r.q;
endmodule // uma_sync3

`default_nettype wire

// ===== uma_irda.sv
`timescale 1ns/10ps
`default_nettype none
`include "uma_regs.svh"

module uma_irda
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  uma_ir_if.codec ir
);
  import uma_pkg::*;

  uma_ir_t r;
  uma_ir_t next_r;

  always_comb
  begin
    next_r = r;
    next_r.rx_prev = ir.rx_pin;
    if (!ir.ir_en)
    begin
      next_r.tx_pulse = 1'b0;
      next_r.tx_cnt = 5'h00;
      next_r.rx_cnt = 5'h00;
      next_r.rx_bit = 1'b1;
    end
    else
    begin
      if (ir.bit_start && !ir.tx_bit)
      begin
        next_r.tx_pulse = 1'b1;
        next_r.tx_cnt = ir.ir11 ? `UMA_IR11_TICKS : `UMA_IR10_TICKS;
      end
      else if (ir.tick && r.tx_cnt != 5'h00)
      begin
        next_r.tx_cnt = r.tx_cnt - 5'h01;
        if (r.tx_cnt == 5'h01)
        begin
          next_r.tx_pulse = 1'b0;
        end
      end
      // A light pulse reads as a zero bit for one bit period; low is idle.
      if (ir.rx_pin && !r.rx_prev)
      begin
        next_r.rx_bit = 1'b0;
        next_r.rx_cnt = `UMA_BIT_TICKS;
      end
      else if (ir.tick && r.rx_cnt != 5'h00)
      begin
        next_r.rx_cnt = r.rx_cnt - 5'h01;
        if (r.rx_cnt == 5'h01)
        begin
          next_r.rx_bit = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      r <= '{tx_cnt: 5'h00, tx_pulse: 1'b0, rx_cnt: 5'h00, rx_prev: 1'b0, rx_bit: 1'b1};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign ir.tx_pulse = r.tx_pulse;
  assign ir.rx_bit = r.rx_bit;
endmodule // uma_irda

`default_nettype wire

// ===== uma_aux_modes_properties.sv
`timescale 1ns/10ps
`default_nettype none

module uma_aux_chk
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_efr_enh,
  input wire logic i_efr_spec,
  input wire logic i_msr_multidrop,
  input wire logic i_mcr_loop,
  input wire logic i_ier_sleep,
  input wire logic i_fcr_wake_ie,
  input wire logic [2:0] i_lcr_parity,
  input wire logic [1:0] i_lcr_wlen,
  input wire logic [7:0] i_second_stop_char,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_char,
  input wire logic i_rx_parity,
  input wire logic i_rx_perr,
  input wire logic i_int_pending,
  input wire logic o_push,
  input wire logic [7:0] o_push_data,
  input wire logic o_push_perr,
  input wire logic o_lsr_int,
  input wire logic o_rx_enabled,
  input wire logic o_wake_int,
  input wire logic o_tx_pin,
  input wire logic o_rts_n,
  input wire logic o_dtr_n,
  input wire logic [3:0] o_modem_n,
  input wire logic o_osc_en,
  input wire logic o_sleep,
  input wire logic o_power_save,
  input wire uma_pkg::uma_bus_t o_bus
);
  import uma_pkg::*;

  // The address compare only looks at the bits of the programmed word length.
  wire logic md = i_efr_enh && i_msr_multidrop && i_lcr_parity == 3'h7;
  wire logic [7:0] mask = 8'hff >> (2'h3 - i_lcr_wlen);
  wire logic hit = ((i_rx_char ^ i_second_stop_char) & mask) == 8'h00;

  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_addr;
    i_rx_valid && i_rx_parity;
  endsequence
  sequence s_store;
    o_push && o_push_perr && o_lsr_int;
  endsequence

  AST_PLAIN_PUSH: assert property (!i_msr_multidrop && i_rx_valid |=> o_push &&
    o_push_data == $past(i_rx_char) && o_push_perr == $past(i_rx_perr))
    else $error("plain character not stored");
  AST_NORM_DATA: assert property (md && !i_efr_spec && !o_rx_enabled &&
    i_rx_valid && !i_rx_parity |=> !o_push) else $error("data byte stored");
  AST_NORM_ADDR: assert property ((md && !i_efr_spec) ##0 s_addr |=> s_store)
    else $error("address byte not flagged");
  AST_AUTO_DROP: assert property (md && i_efr_spec && i_rx_valid &&
    (i_rx_parity ? !hit : !o_rx_enabled) |=> !o_push) else $error("byte not dropped");
  AST_AUTO_HIT: assert property ((md && i_efr_spec && hit) ##0 s_addr |=>
    s_store and o_rx_enabled) else $error("matching address not taken");
  AST_AUTO_MISS: assert property ((md && i_efr_spec && !hit) ##0 s_addr |=>
    !o_rx_enabled) else $error("mismatch left receiver on");
  AST_LOOP: assert property (i_mcr_loop |=> o_tx_pin && o_rts_n && o_dtr_n &&
    o_modem_n == 4'hf) else $error("loopback pins not inactive");
  AST_OSC: assert property (o_osc_en == !o_sleep)
    else $error("oscillator state wrong");
  AST_INT_BLOCK: assert property (!o_sleep && i_int_pending |=> !o_sleep)
    else $error("slept with interrupt pending");
  AST_SLEEP_OFF: assert property (!i_ier_sleep |=> !o_sleep)
    else $error("asleep while disabled");
  AST_PS_SLEEP: assert property (o_power_save |-> o_sleep)
    else $error("power save while awake");
  AST_PS_BUS: assert property (o_power_save && $past(o_power_save) |-> $stable(o_bus))
    else $error("bus moved in power save");
  AST_WAKE_OFF: assert property (!i_fcr_wake_ie |=> !o_wake_int)
    else $error("wake interrupt while disabled");
endmodule // uma_aux_chk

bind uma_aux_modes uma_aux_chk u_chk (.*);

`default_nettype wire

// ===== uma_peer.sv
`timescale 1ns/10ps
`default_nettype none

module uma_peer
(
  input wire logic i_clk,
  input wire logic i_ir,
  input wire logic i_start,
  input wire logic i_toggle,
  output logic o_rx_pin,
  output logic [3:0] o_modem_n
);
  logic [4:0] left;

  initial left = 5'h00;
  initial o_modem_n = 4'hf;

  // A start bit or light pulse lasts 16 clocks, then the line returns to idle.
  always @(posedge i_clk)
  begin
    left <= i_start ? 5'h10 : left - {4'h0, left != 5'h00};
    if (i_toggle)
      o_modem_n <= o_modem_n ^ 4'h1;
  end

  assign o_rx_pin = (left != 5'h00) ~^ i_ir;
endmodule // uma_peer

`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import uma_pkg::*;
  logic i_clk, i_rst_n, i_efr_enh, i_efr_spec, i_msr_multidrop, i_msr_ir11, i_mcr_ir;
  logic i_mcr_loop, i_mcr_rts, i_mcr_dtr, i_ier_sleep, i_fcr_wake_ie, i_rx_valid;
  logic i_rx_parity, i_rx_perr, i_rx_en_set, i_rx_en_clr, i_int_pending, i_divisor_nz;
  logic i_txf_empty, i_rxf_empty, i_thr_write, i_msr_read, i_isr_read, i_tick16;
  logic i_bit_start, i_tx_shift, i_power_save_pin, ir_idle, start, tog, en;
  logic o_push, o_push_perr, o_lsr_int, o_rx_enabled, o_wake_int, o_tx_pin, o_rts_n;
  logic o_dtr_n, o_rx_serial, o_osc_en, o_sleep, o_power_save;
  wire logic i_rx_pin, i_cts_n, i_dsr_n, i_cd_n, i_ri_n;
  logic [2:0] i_lcr_parity;
  logic [1:0] i_lcr_wlen;
  logic [7:0] i_second_stop_char, i_rx_char, o_push_data;
  logic [3:0] i_msr_delta, o_modem_n;
  uma_bus_t i_bus, o_bus, b;
  int errors = 0, samples_checked = 0, cycles = 0, seed = 32'h550e8986, n;

  uma_aux_modes dut (.*);
  uma_peer peer (.i_clk(i_clk), .i_ir(ir_idle), .i_start(start), .i_toggle(tog),
    .o_rx_pin(i_rx_pin), .o_modem_n({i_ri_n, i_cd_n, i_dsr_n, i_cts_n}));

  always #12.5 i_clk = ~i_clk;

  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      errors++;
      close_out();
    end
  end

  task close_out;
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(posedge i_clk);
    #2;
  endtask

  task pulse_ok(input logic want);
    n = 0;
    while (o_sleep !== want && n < 80)
    begin
      cyc(1);
      n++;
    end
    check("sleep", o_sleep, want);
    check("osc_en", o_osc_en, !want);
  endtask

  task do_reset;
    i_rst_n = 0;
    cyc(6);
    check("reset", {o_push, o_lsr_int, o_rx_enabled, o_wake_int, o_tx_pin, o_rts_n, o_dtr_n,
      o_rx_serial, o_modem_n, o_osc_en, o_sleep, o_power_save}, 16'h07fc);
    i_rst_n = 1;
  endtask

  function automatic logic exp_push(logic [1:0] em, logic par, logic hit, logic on);
    return em == 2'h0 || (par ? em == 2'h1 || hit : on);
  endfunction

  task rx_phase(input logic [1:0] m, input logic [2:0] pf, input logic enh);
    logic [1:0] em;
    logic [7:0] ch, mask;
    logic par, hit, push;
    do_reset;
    en = 0;
    em = (pf == 3'h7 && enh) ? m : 2'h0;
    {i_efr_enh, i_msr_multidrop, i_efr_spec, i_lcr_parity} = {enh, m != 2'h0, m[1], pf};
    {i_lcr_wlen, i_second_stop_char} = $random(seed);
    mask = 8'hff >> (2'h3 - i_lcr_wlen);
    repeat (24)
    begin
      n = $random(seed);
      if (em == 2'h1)
      begin
        {i_rx_en_clr, i_rx_en_set} = n[12:11];
        cyc(1);
        en = n[11] | (en & ~n[12]);
        {i_rx_en_clr, i_rx_en_set} = 2'h0;
      end
      par = n[8];
      ch = n[9] ? (i_second_stop_char & mask) | (n[7:0] & ~mask) : n[7:0];
      hit = ((ch ^ i_second_stop_char) & mask) == 8'h00;
      {i_rx_char, i_rx_parity, i_rx_perr, i_rx_valid} = {ch, par, n[10] & em == 2'h0, 1'b1};
      cyc(1);
      i_rx_valid = 0;
      push = exp_push(em, par, hit, en);
      if (em == 2'h2 && par)
        en = hit;
      check("push", o_push, push);
      check("rx_enabled", o_rx_enabled, en);
      if (push)
        check("push_data", {o_push_perr, o_push_data}, {em != 2'h0 ? par : n[10], ch});
      if (em != 2'h0)
        check("lsr_int", o_lsr_int, par && push);
    end
  endtask

  task ir_tx(input logic enh, input logic v11, input logic bt, input int w);
    {i_efr_enh, i_msr_ir11, i_tx_shift, i_mcr_ir, i_tick16} = {enh, v11, bt, 2'h3};
    cyc(20);
    i_bit_start = 1;
    cyc(1);
    i_bit_start = 0;
    n = 0;
    repeat (20)
    begin
      cyc(1);
      n += o_tx_pin;
    end
    check("ir_pulse", n[15:0], w[15:0]);
  endtask

  initial
  begin
    {i_clk, i_rst_n, i_efr_enh, i_efr_spec, i_msr_multidrop, i_msr_ir11, i_mcr_ir} = '0;
    {i_mcr_loop, i_mcr_rts, i_mcr_dtr, i_ier_sleep, i_fcr_wake_ie, i_rx_valid} = '0;
    {i_rx_parity, i_rx_perr, i_rx_en_set, i_rx_en_clr, i_int_pending, i_divisor_nz} = '0;
    {i_txf_empty, i_rxf_empty, i_thr_write, i_msr_read, i_isr_read, i_tick16} = '0;
    {i_bit_start, i_tx_shift, i_power_save_pin, ir_idle, start, tog, en} = '0;
    {i_lcr_parity, i_lcr_wlen, i_second_stop_char, i_rx_char, i_msr_delta, i_bus} = '0;
    rx_phase(2'h0, 3'h7, 1);
    rx_phase(2'h1, 3'h7, 1);
    rx_phase(2'h2, 3'h7, 1);
    rx_phase(2'h2, 3'h3, 1);
    rx_phase(2'h1, 3'h7, 0);
    {i_mcr_loop, i_mcr_rts, i_mcr_dtr, tog} = 4'hf;
    repeat (8)
    begin
      n = $random(seed);
      i_tx_shift = n[0];
      cyc(2);
      check("loop_rx", o_rx_serial, n[0]);
      check("loop_pins", {o_tx_pin, o_rts_n, o_dtr_n, o_modem_n}, 16'h7f);
    end
    {i_mcr_loop, tog} = 2'h0;
    cyc(6);
    check("modem", {o_rts_n, o_dtr_n, o_modem_n}, {2'h0, i_ri_n, i_cd_n, i_dsr_n, i_cts_n});
    ir_tx(0, 0, 0, 3);
    ir_tx(0, 1, 0, 3);
    ir_tx(1, 1, 0, 4);
    ir_tx(1, 0, 1, 0);
    ir_idle = 1;
    cyc(8);
    check("ir_idle", o_rx_serial, 1);
    start = 1;
    cyc(1);
    start = 0;
    n = 0;
    repeat (40)
    begin
      cyc(1);
      n += !o_rx_serial;
    end
    check("ir_rx", n[15:0], 16'h10);
    {ir_idle, i_mcr_ir, i_fcr_wake_ie} = 3'h1;
    do_reset;
    for (int k = 0; k < 6; k++)
    begin
      {i_int_pending, i_msr_delta[0], i_divisor_nz, i_txf_empty, i_rxf_empty, i_ier_sleep} =
        6'h0f ^ (6'h20 >> k);
      cyc(10);
      check("sleep_blocked", o_sleep, 0);
    end
    {i_int_pending, i_msr_delta[0], i_divisor_nz, i_txf_empty, i_rxf_empty, i_ier_sleep} = 6'h0f;
    pulse_ok(1);
    for (int s = 0; s < 4; s++)
    begin
      {i_fcr_wake_ie, tog, start, i_thr_write} = {s != 3, 3'h1 << (s % 3)};
      cyc(1);
      {tog, start, i_thr_write} = 3'h0;
      pulse_ok(0);
      check("wake_int", o_wake_int, s != 3);
      i_isr_read = 1;
      cyc(1);
      i_isr_read = 0;
      cyc(1);
      check("wake_clear", o_wake_int, 0);
      if (s == 2)
      begin
        cyc(20);
        check("modem_hold", o_sleep, 0);
        i_msr_read = 1;
        cyc(1);
        i_msr_read = 0;
      end
      pulse_ok(1);
    end
    b = $random(seed);
    i_bus = b;
    i_power_save_pin = 1;
    cyc(8);
    check("power_save", o_power_save, 1);
    i_thr_write = 1;
    repeat (6)
    begin
      i_bus = $random(seed);
      cyc(1);
      i_thr_write = 0;
      check("bus_frozen", o_bus, b);
    end
    check("ps_thr", o_sleep, 1);
    start = 1;
    cyc(1);
    start = 0;
    pulse_ok(0);
    pulse_ok(1);
    cyc(2);
    check("ps_back", o_power_save, 1);
    i_power_save_pin = 0;
    cyc(8);
    check("ps_pin_low", o_power_save, 0);
    i_ier_sleep = 0;
    cyc(2);
    check("sleep_off", o_sleep, 0);
    close_out();
  end
endmodule // tb_top

`default_nettype wire
